// ===== bench/asr_host.sv
// Host model driving the register strobe port of the rate control block
`timescale 1ns/10ps
module asr_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  import asr_pkg::*;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Fields other than the active bit are only changed from standby
  task automatic set_ctrl1(input logic [7:0] v);
    wr(ASR_REG_CTRL1, 8'h00);
    wr(ASR_REG_CTRL1, v & 8'hFE);
    if (v[0]) begin
      wr(ASR_REG_CTRL1, v);
    end
  endtask
endmodule

// ===== bench/asr_top_test.sv
// Self-checking bench for auto-sleep and sample rate control
`timescale 1ns/10ps
module asr_top_test;
  import asr_pkg::*;
  localparam int U = 4;
  logic sys_clk, rst, reg_wr, reg_rd, ptr_load, ptr_adv, new_data_event;
  logic sleep_wake_event, low_noise_sel, slept, fast_read_sel;
  logic self_check_enable, new_data_irq_en, irq_active_high, irq_open_drain;
  logic [1:0] oversample_scheme;
  logic [3:0] func_irq_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ptr_load_addr, ptr_addr;
  logic [7:0] d, q, lim, base;
  logic [7:0] swe_cnt = 8'h00;
  logic [3:0] ev;
  logic [2:0] output_sample_rate, code;
  asr_state_t power_state;
  int errors, check_count, cyc, i, n, seed;
  logic [7:0] wm [5] = '{8'hFF, 8'hFE, 8'hBF, 8'hFF, 8'hFF};
  logic [7:0] msk [5] = '{8'hFF, 8'hFF, ASR_C2_MASK, ASR_WAKECFG_MASK,
    ASR_INTEN_MASK};
  // Register bits that are also shown on a dedicated output
  logic [7:0] pm [5] = '{8'h00, 8'h06, 8'h80, 8'h03, 8'h3D};

  asr_top #(.UNIT_CYCLES(U)) u_asr_top (
    .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ptr_load(ptr_load), .ptr_load_addr(ptr_load_addr),
    .ptr_adv(ptr_adv), .ptr_addr(ptr_addr),
    .transient_event(ev[3]), .orientation_event(ev[2]),
    .tap_event(ev[1]), .freefall_motion_event(ev[0]),
    .new_data_event(new_data_event), .sleep_wake_event(sleep_wake_event),
    .power_state(power_state), .output_sample_rate(output_sample_rate),
    .oversample_scheme(oversample_scheme), .low_noise_sel(low_noise_sel),
    .fast_read_sel(fast_read_sel), .self_check_enable(self_check_enable),
    .func_irq_en(func_irq_en), .new_data_irq_en(new_data_irq_en),
    .irq_active_high(irq_active_high), .irq_open_drain(irq_open_drain)
  );

  asr_host u_asr_host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (sleep_wake_event === 1'b1) begin
      swe_cnt <= swe_cnt + 8'h01;
    end
    if (cyc == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_st(input string nm, input asr_state_t e,
                        input asr_state_t g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Inactivity time in cycles for a count at a given wake rate code
  function automatic int sleep_cyc(input logic [7:0] l, input logic [2:0] c);
    sleep_cyc = l * U * ((c == 3'h7) ? 2 : 1);
  endfunction

  function automatic logic [7:0] in_win(input int m, input int e);
    in_win = (m >= e && m <= e + 3) ? 8'h01 : 8'h00;
  endfunction

  // Output pins gathered at the bit places of their register
  function automatic logic [7:0] pins(input int k);
    case (k)
      1: pins = {5'h00, low_noise_sel, fast_read_sel, 1'b0};
      2: pins = {self_check_enable, 7'h00};
      3: pins = {6'h00, irq_active_high, irq_open_drain};
      4: pins = {2'h0, func_irq_en, 1'b0, new_data_irq_en};
      default: pins = 8'h00;
    endcase
  endfunction

  task automatic pulse(input int k);
    @(negedge sys_clk);
    ev[k] = 1'b1;
    @(negedge sys_clk);
    ev[k] = 1'b0;
  endtask

  task automatic wait_st(input asr_state_t s, input int l, output int m);
    m = 0;
    while (power_state !== s && m < l) begin
      @(negedge sys_clk);
      m++;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ptr_load = 1'b0;
    ptr_adv = 1'b0;
    ptr_load_addr = 8'h00;
    ev = 4'h0;
    new_data_event = 1'b0;
    seed = 32'h61CC350A;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    chk_st("reset state", ASR_STANDBY, power_state);
    chk8("reset rate", 8'h00, {5'h00, output_sample_rate});
    // Last address is unmapped
    for (i = 0; i < 6; i++) begin
      u_asr_host.rd(8'h29 + i[7:0], q);
      chk8("reset value", 8'h00, q);
    end
    $display("test reset done");
    repeat (4) begin
      for (i = 0; i < 5; i++) begin
        d = 8'($random(seed)) & wm[i];
        u_asr_host.wr(8'h29 + i[7:0], d);
        u_asr_host.rd(8'h29 + i[7:0], q);
        chk8("readback", d & msk[i], q);
        if (i > 0) begin
          chk8("field view", d & pm[i], pins(i));
        end
      end
    end
    u_asr_host.wr(ASR_REG_CTRL2, 8'h40);
    for (i = 0; i < 5; i++) begin
      u_asr_host.rd(8'h29 + i[7:0], q);
      chk8("soft reset value", 8'h00, q);
    end
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      d = {2'b00, i[2:0], 3'b001} | (8'($random(seed)) & 8'h04);
      u_asr_host.set_ctrl1(d);
      @(negedge sys_clk);
      chk_st("active state", ASR_WAKE, power_state);
      chk8("wake rate", {5'h00, i[2:0]}, {5'h00, output_sample_rate});
      chk8("low noise", {7'h00, d[2]}, {7'h00, low_noise_sel});
    end
    u_asr_host.wr(ASR_REG_CTRL1, 8'h18);
    @(negedge sys_clk);
    chk_st("back to standby", ASR_STANDBY, power_state);
    $display("test wake rates done");
    for (i = 0; i < 2; i++) begin
      u_asr_host.set_ctrl1({6'h00, i[0], 1'b0});
      @(negedge sys_clk);
      ptr_load = 1'b1;
      ptr_load_addr = 8'h01;
      @(negedge sys_clk);
      ptr_load = 1'b0;
      ptr_adv = 1'b1;
      @(negedge sys_clk);
      ptr_adv = 1'b0;
      chk8("burst step", 8'h02 + {7'h00, i[0]}, ptr_addr);
    end
    $display("test burst done");
    u_asr_host.wr(ASR_REG_CTRL2, 8'h15);
    for (i = 0; i < 4; i++) begin
      lim = 8'h01 + (8'($random(seed)) & 8'h03);
      code = (i == 3) ? 3'h7 : 3'h3 + i[2:0];
      u_asr_host.wr(ASR_REG_INACT, lim);
      u_asr_host.wr(ASR_REG_INTEN, 8'h80);
      u_asr_host.wr(ASR_REG_WAKECFG, 8'h08 << i);
      base = swe_cnt;
      u_asr_host.set_ctrl1({i[1:0], code, 3'b001});
      wait_st(ASR_WAKE, 4, n);
      wait_st(ASR_SLEEP, 300, n);
      chk8("sleep delay", 8'h01, in_win(n, sleep_cyc(lim, code)));
      chk8("sleep rate", {6'h01, i[1:0]}, 8'(output_sample_rate));
      chk8("sleep scheme", 8'h02, {6'h00, oversample_scheme});
      pulse(i);
      @(negedge sys_clk);
      chk_st("no enable no wake", ASR_SLEEP, power_state);
      u_asr_host.wr(ASR_REG_INTEN, 8'h80 | (8'h04 << i));
      pulse(i);
      @(negedge sys_clk);
      chk_st("woken", ASR_WAKE, power_state);
      chk8("rate on wake", {5'h00, code}, 8'(output_sample_rate));
      chk8("wake scheme", 8'h01, {6'h00, oversample_scheme});
      wait_st(ASR_SLEEP, 300, n);
      chk8("resleep delay", 8'h01, in_win(n, sleep_cyc(lim, code)));
      @(negedge sys_clk);
      chk8("sleep wake pulses", base + 8'h03, swe_cnt);
    end
    $display("test sleep and wake done");
    u_asr_host.wr(ASR_REG_INACT, 8'h02);
    u_asr_host.wr(ASR_REG_INTEN, 8'h3C);
    u_asr_host.wr(ASR_REG_WAKECFG, 8'h00);
    base = swe_cnt;
    u_asr_host.set_ctrl1(8'h19);
    slept = 1'b0;
    repeat (20) begin
      pulse($unsigned($random(seed)) % 4);
      @(negedge sys_clk);
      if (power_state === ASR_SLEEP) begin
        slept = 1'b1;
      end
    end
    chk8("kept awake", 8'h00, {7'h00, slept});
    n = 0;
    while (power_state !== ASR_SLEEP && n < 40) begin
      @(negedge sys_clk);
      new_data_event = ~new_data_event;
      n++;
    end
    d = in_win(n, sleep_cyc(8'h02, 3'h3));
    chk8("data ready ignored", 8'h01, d);
    repeat (4) begin
      @(negedge sys_clk);
      new_data_event = ~new_data_event;
    end
    new_data_event = 1'b0;
    chk_st("data ready no wake", ASR_SLEEP, power_state);
    chk8("irq gated", base, swe_cnt);
    $display("test restart done");
    u_asr_host.wr(ASR_REG_CTRL2, 8'h00);
    u_asr_host.set_ctrl1(8'h19);
    wait_st(ASR_SLEEP, 60, n);
    chk8("no auto sleep", 8'h3C, n[7:0]);
    chk_st("stays awake", ASR_WAKE, power_state);
    $display("test auto sleep off done");
    complete_run();
  end
endmodule

// ===== pkg/asr_pkg.sv
// Package: register map, field layout, states and timing for rate control
package asr_pkg;

  // Register offsets
  localparam logic [7:0] ASR_REG_INACT = 8'h29;
  localparam logic [7:0] ASR_REG_CTRL1 = 8'h2A;
  localparam logic [7:0] ASR_REG_CTRL2 = 8'h2B;
  localparam logic [7:0] ASR_REG_WAKECFG = 8'h2C;
  localparam logic [7:0] ASR_REG_INTEN = 8'h2D;

  // Reset values
  localparam logic [7:0] ASR_RST_INACT = 8'h00;
  localparam logic [7:0] ASR_RST_CTRL1 = 8'h00;
  localparam logic [7:0] ASR_RST_CTRL2 = 8'h00;
  localparam logic [7:0] ASR_RST_WAKECFG = 8'h00;
  localparam logic [7:0] ASR_RST_INTEN = 8'h00;
  localparam logic [7:0] ASR_RD_NONE = 8'h00;

  // system_control_one fields
  localparam int ASR_C1_SLEEP_LSB = 6;
  localparam int ASR_C1_RATE_LSB = 3;
  localparam int ASR_C1_LOW_NOISE_SEL = 2;
  localparam int ASR_C1_FREAD = 1;
  localparam int ASR_C1_ACTIVE = 0;

  // system_control_two fields; bit 6 is the self-clearing soft reset
  localparam int ASR_C2_SELF = 7;
  localparam int ASR_C2_SWRST = 6;
  localparam int ASR_C2_SLEEP_OVERSAMPLE_SCHEME_LSB = 3;
  localparam int ASR_C2_AUTO_SLEEP_EN = 2;
  localparam int ASR_C2_WAKE_OVERSAMPLE_SCHEME_LSB = 0;

  // Stored-bit masks; other bits read as zero
  localparam logic [7:0] ASR_C2_MASK = 8'h9F;
  localparam logic [7:0] ASR_WAKECFG_MASK = 8'h7B;
  localparam logic [7:0] ASR_INTEN_MASK = 8'hBD;

  // wake_source_config and interrupt_enable_config fields
  localparam int ASR_WAKE_LSB = 3;
  localparam int ASR_IPOL = 1;
  localparam int ASR_PPOD = 0;
  localparam int ASR_IEN_FUNC_LSB = 2;
  localparam int ASR_IEN_SLEEP = 7;
  localparam int ASR_IEN_DRDY = 0;
  localparam int ASR_NUM_FUNC = 4;

  // Rate codes
  localparam logic [2:0] ASR_RATE_SLOWEST = 3'h7;
  localparam logic ASR_SLEEP_RATE_MSB = 1'b1;

  // Timing
  localparam int ASR_CLK_KHZ = 125000;
  localparam int ASR_UNIT_MS = 320;
  localparam int ASR_SLOW_UNIT_MS = 640;
  localparam int ASR_SLOW_RATIO = ASR_SLOW_UNIT_MS / ASR_UNIT_MS;
  localparam int ASR_UNIT_CYCLES = ASR_UNIT_MS * ASR_CLK_KHZ;

  // Burst pointer data region defaults (plain defaults)
  localparam logic [7:0] ASR_DATA_FIRST = 8'h01;
  localparam logic [7:0] ASR_DATA_LAST = 8'h06;
  localparam logic [7:0] ASR_STEP_ONE = 8'h01;
  localparam logic [7:0] ASR_STEP_TWO = 8'h02;

  typedef enum logic [1:0] {
    ASR_STANDBY = 2'b00,
    ASR_WAKE = 2'b01,
    ASR_SLEEP = 2'b11
  } asr_state_t;

  // Sleep rate code mapped onto the wake rate code space
  function automatic logic [2:0] asr_sleep_odr(input logic [1:0] sel);
    asr_sleep_odr = {ASR_SLEEP_RATE_MSB, sel};
  endfunction

endpackage

// ===== rtl/asr_burst_ptr.sv
// Burst read address pointer with fast-read skipping of low data bytes
`timescale 1ns/10ps
module asr_burst_ptr #(
  parameter logic [7:0] DATA_FIRST = asr_pkg::ASR_DATA_FIRST,
  parameter logic [7:0] DATA_LAST = asr_pkg::ASR_DATA_LAST
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_load_addr,
  input wire logic ptr_adv,
  input wire logic fast_read,
  output logic [7:0] ptr_addr
);
  import asr_pkg::*;

  generate
    if (DATA_LAST <= DATA_FIRST) begin
      $error("data region must span at least two bytes");
    end
  endgenerate

  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  wire in_data = (ptr_r >= DATA_FIRST) && (ptr_r < DATA_LAST);
  wire [7:0] step = (fast_read && in_data) ? ASR_STEP_TWO : ASR_STEP_ONE;

  // High bytes sit at even distance from the first data byte
  assign ptr_nxt = ptr_load ? ptr_load_addr :
                   ptr_adv ? ptr_r + step : ptr_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_r <= 8'h00;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  assign ptr_addr = ptr_r;

endmodule

// ===== rtl/asr_inact_timer.sv
// Inactivity timer: counts elapsed count units while running
`timescale 1ns/10ps
module asr_inact_timer #(
  parameter int unsigned UNIT_CYCLES = asr_pkg::ASR_UNIT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic slow_unit,
  input wire logic [7:0] limit,
  output logic [7:0] elapsed,
  output logic expired
);
  import asr_pkg::*;

  localparam logic [31:0] UNIT_LEN = 32'(UNIT_CYCLES);
  localparam logic [31:0] SLOW_LEN = 32'(UNIT_CYCLES * ASR_SLOW_RATIO);

  generate
    if (UNIT_CYCLES < 1 ||
        64'(UNIT_CYCLES) * 64'(ASR_SLOW_RATIO) > 64'hFFFFFFFF) begin
      $error("UNIT_CYCLES out of range");
    end
  endgenerate

  logic [31:0] pre_r;
  logic [31:0] pre_nxt;
  logic [7:0] elapsed_r;
  logic [7:0] elapsed_nxt;
  wire [31:0] unit_len = slow_unit ? SLOW_LEN : UNIT_LEN;
  wire unit_tick = (pre_r >= unit_len - 32'h1);
  wire sat = (elapsed_r == 8'hFF);

  assign pre_nxt = (restart || !run || unit_tick) ? 32'h0 : pre_r + 32'h1;
  assign elapsed_nxt = (restart || !run) ? 8'h00 :
                       (unit_tick && !sat) ? elapsed_r + 8'h01 : elapsed_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_r <= 32'h0;
      elapsed_r <= 8'h00;
    end else begin
      pre_r <= pre_nxt;
      elapsed_r <= elapsed_nxt;
    end
  end

  assign elapsed = elapsed_r;
  // Unit length doubles at the slowest wake rate
  assign expired = run && (elapsed_r >= limit);

endmodule

// ===== rtl/asr_top.sv
// Auto-sleep and sample rate control with its control registers
// What this block does
// - In auto-sleep, go to sleep rate after inactivity of programmed count.
// - Count unit is 320 ms, or 640 ms at the slowest wake rate.
// - Enabled transient, orientation, tap, motion events restart the inactivity timer.
// - A function wakes only if interrupt enabled and selected as wake source.
// - Asleep, enabled functions run at sleep rate; only wake sources wake.
// - Sleep/wake and new-data interrupts never change wake or sleep state.
// - Without auto-sleep, move only between standby and wake.
// - With its enable set, each wake-sleep transition raises the interrupt.
// - Sleep rate field bits 7:6 select 50, 12.5, 6.25, 1.56 Hz.
// - In sleep, system and block rates follow the sleep rate field.
// - Rate field bits 5:3 select 800 down to 1.56 Hz; resets 000.
// - Bit 0 selects standby at 0, active at 1; resets to 0.
// - Low-noise bit limits measurable range to plus or minus 4 g.
// - Fast-read makes burst auto-increment skip low data bytes.
// - Auto-sleep enable bit in control two; resets to 0.
// - Wake-source bits let each function wake from sleep; reset 0.
// - Sleep/wake interrupt enable gates that interrupt; resets disabled.
`timescale 1ns/10ps
module asr_top #(
  parameter int unsigned UNIT_CYCLES = asr_pkg::ASR_UNIT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_load_addr,
  input wire logic ptr_adv,
  output logic [7:0] ptr_addr,
  input wire logic transient_event,
  input wire logic orientation_event,
  input wire logic tap_event,
  input wire logic freefall_motion_event,
  input wire logic new_data_event,
  output logic sleep_wake_event,
  output asr_pkg::asr_state_t power_state,
  output logic [2:0] output_sample_rate,
  output logic [1:0] oversample_scheme,
  output logic low_noise_sel,
  output logic fast_read_sel,
  output logic self_check_enable,
  output logic [3:0] func_irq_en,
  output logic new_data_irq_en,
  output logic irq_active_high,
  output logic irq_open_drain
);
  import asr_pkg::*;

  logic [7:0] inact_r;
  logic [7:0] inact_nxt;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl1_nxt;
  logic [7:0] ctrl2_r;
  logic [7:0] ctrl2_nxt;
  logic [7:0] wakecfg_r;
  logic [7:0] wakecfg_nxt;
  logic [7:0] inten_r;
  logic [7:0] inten_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  asr_state_t state_r;
  asr_state_t state_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [2:0] osr_r;
  logic [2:0] osr_nxt;
  logic [1:0] scheme_r;
  logic [1:0] scheme_nxt;
  logic [7:0] elapsed;
  logic expired;

  // Register access decode
  wire wr_inact = reg_wr && (reg_addr == ASR_REG_INACT);
  wire wr_c1 = reg_wr && (reg_addr == ASR_REG_CTRL1);
  wire wr_c2 = reg_wr && (reg_addr == ASR_REG_CTRL2);
  wire wr_wake = reg_wr && (reg_addr == ASR_REG_WAKECFG);
  wire wr_inten = reg_wr && (reg_addr == ASR_REG_INTEN);
  wire swrst = wr_c2 && reg_wdata[ASR_C2_SWRST];

  // Field views
  wire active_bit = ctrl1_r[ASR_C1_ACTIVE];
  wire [2:0] wake_rate = ctrl1_r[ASR_C1_RATE_LSB +: 3];
  wire [1:0] sleep_rate = ctrl1_r[ASR_C1_SLEEP_LSB +: 2];
  wire slp_en = ctrl2_r[ASR_C2_AUTO_SLEEP_EN];
  wire sw_irq_en = inten_r[ASR_IEN_SLEEP];
  wire [3:0] fen = inten_r[ASR_IEN_FUNC_LSB +: ASR_NUM_FUNC];
  wire [3:0] wsel = wakecfg_r[ASR_WAKE_LSB +: ASR_NUM_FUNC];
  // Order matches the wake-source and interrupt-enable bit order
  wire [3:0] func_ev = {transient_event, orientation_event, tap_event,
                        freefall_motion_event};

  // Only the four detection functions count; new data never does
  wire restart_hit = |(func_ev & fen);
  wire wake_hit = |(func_ev & fen & wsel);

  // Register next values; soft reset restores every default
  assign inact_nxt = swrst ? ASR_RST_INACT :
                     wr_inact ? reg_wdata : inact_r;
  // While active only the standby/active bit takes a write
  assign ctrl1_nxt = swrst ? ASR_RST_CTRL1 :
                     !wr_c1 ? ctrl1_r :
                     active_bit ? {ctrl1_r[7:1], reg_wdata[ASR_C1_ACTIVE]} :
                     reg_wdata;
  assign ctrl2_nxt = swrst ? ASR_RST_CTRL2 :
                     wr_c2 ? (reg_wdata & ASR_C2_MASK) : ctrl2_r;
  assign wakecfg_nxt = swrst ? ASR_RST_WAKECFG :
                       wr_wake ? (reg_wdata & ASR_WAKECFG_MASK) :
                       wakecfg_r;
  assign inten_nxt = swrst ? ASR_RST_INTEN :
                     wr_inten ? (reg_wdata & ASR_INTEN_MASK) : inten_r;

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux = (reg_addr == ASR_REG_INACT) ? inact_r :
                      (reg_addr == ASR_REG_CTRL1) ? ctrl1_r :
                      (reg_addr == ASR_REG_CTRL2) ? ctrl2_r :
                      (reg_addr == ASR_REG_WAKECFG) ? wakecfg_r :
                      (reg_addr == ASR_REG_INTEN) ? inten_r : ASR_RD_NONE;
  assign rdata_nxt = reg_rd ? rd_mux : rdata_r;

  // Power state sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ASR_STANDBY: begin
        if (active_bit) begin
          state_nxt = ASR_WAKE;
        end
      end
      ASR_WAKE: begin
        if (!active_bit) begin
          state_nxt = ASR_STANDBY;
        end else if (slp_en && expired) begin
          state_nxt = ASR_SLEEP;
        end
      end
      ASR_SLEEP: begin
        if (!active_bit) begin
          state_nxt = ASR_STANDBY;
        end else if (!slp_en || wake_hit) begin
          state_nxt = ASR_WAKE;
        end
      end
      default: begin
        state_nxt = ASR_STANDBY;
      end
    endcase
    if (swrst) begin
      state_nxt = ASR_STANDBY;
    end
  end

  wire to_sleep = (state_r == ASR_WAKE) && (state_nxt == ASR_SLEEP);
  wire to_wake = (state_r == ASR_SLEEP) && (state_nxt == ASR_WAKE);
  assign irq_nxt = sw_irq_en && (to_sleep || to_wake);

  // Effective rate and oversampling scheme follow the next state
  wire sleep_nxt = (state_nxt == ASR_SLEEP);
  assign osr_nxt = sleep_nxt ?
                   asr_sleep_odr(ctrl1_nxt[ASR_C1_SLEEP_LSB +: 2]) :
                   ctrl1_nxt[ASR_C1_RATE_LSB +: 3];
  assign scheme_nxt = sleep_nxt ? ctrl2_nxt[ASR_C2_SLEEP_OVERSAMPLE_SCHEME_LSB +: 2] :
                      ctrl2_nxt[ASR_C2_WAKE_OVERSAMPLE_SCHEME_LSB +: 2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inact_r <= ASR_RST_INACT;
      ctrl1_r <= ASR_RST_CTRL1;
      ctrl2_r <= ASR_RST_CTRL2;
      wakecfg_r <= ASR_RST_WAKECFG;
      inten_r <= ASR_RST_INTEN;
      rdata_r <= ASR_RD_NONE;
      state_r <= ASR_STANDBY;
      irq_r <= 1'b0;
      osr_r <= ASR_RST_CTRL1[ASR_C1_RATE_LSB +: 3];
      scheme_r <= ASR_RST_CTRL2[ASR_C2_WAKE_OVERSAMPLE_SCHEME_LSB +: 2];
    end else begin
      inact_r <= inact_nxt;
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      wakecfg_r <= wakecfg_nxt;
      inten_r <= inten_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      irq_r <= irq_nxt;
      osr_r <= osr_nxt;
      scheme_r <= scheme_nxt;
    end
  end

  // Timer runs only awake with auto-sleep on; held at zero otherwise
  asr_inact_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run((state_r == ASR_WAKE) && slp_en && !swrst),
    .restart(restart_hit),
    .slow_unit(wake_rate == ASR_RATE_SLOWEST),
    .limit(inact_r),
    .elapsed(elapsed),
    .expired(expired)
  );

  asr_burst_ptr u_ptr (
    .sys_clk(sys_clk),
    .rst(rst),
    .ptr_load(ptr_load),
    .ptr_load_addr(ptr_load_addr),
    .ptr_adv(ptr_adv),
    .fast_read(ctrl1_r[ASR_C1_FREAD]),
    .ptr_addr(ptr_addr)
  );

  assign reg_rdata = rdata_r;
  assign sleep_wake_event = irq_r;
  assign power_state = state_r;
  assign output_sample_rate = osr_r;
  assign oversample_scheme = scheme_r;
  // Front end clamps to the reduced range when set
  assign low_noise_sel = ctrl1_r[ASR_C1_LOW_NOISE_SEL];
  assign fast_read_sel = ctrl1_r[ASR_C1_FREAD];
  assign self_check_enable = ctrl2_r[ASR_C2_SELF];
  assign func_irq_en = fen;
  assign new_data_irq_en = inten_r[ASR_IEN_DRDY];
  assign irq_active_high = wakecfg_r[ASR_IPOL];
  assign irq_open_drain = wakecfg_r[ASR_PPOD];

  property p_no_sleep_without_en;
    @(posedge sys_clk) disable iff (rst)
      (!slp_en && state_r != ASR_SLEEP) |=> (state_r != ASR_SLEEP);
  endproperty
  a_no_sleep_without_en: assert property (p_no_sleep_without_en)
    else $error("sleep entered with auto-sleep disabled");

  property p_sleep_after_limit;
    @(posedge sys_clk) disable iff (rst)
      ($past(state_r) == ASR_WAKE && state_r == ASR_SLEEP) |->
        ($past(elapsed) >= $past(inact_r) && $past(slp_en));
  endproperty
  a_sleep_after_limit: assert property (p_sleep_after_limit)
    else $error("sleep entered before inactivity limit");

  property p_irq_on_transition;
    @(posedge sys_clk) disable iff (rst)
      ($past(sw_irq_en) && $past(state_r) != state_r &&
       $past(state_r) != ASR_STANDBY && state_r != ASR_STANDBY) |->
        sleep_wake_event;
  endproperty
  a_irq_on_transition: assert property (p_irq_on_transition)
    else $error("sleep/wake transition without interrupt");

  property p_irq_gated;
    @(posedge sys_clk) disable iff (rst)
      !sw_irq_en |=> !sleep_wake_event;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("sleep/wake interrupt while disabled");

  property p_stay_asleep;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ASR_SLEEP && !wake_hit && slp_en && active_bit &&
       !swrst) |=> (state_r == ASR_SLEEP);
  endproperty
  a_stay_asleep: assert property (p_stay_asleep)
    else $error("woke without an enabled wake source");

  property p_wake_restart;
    @(posedge sys_clk) disable iff (rst)
      ($past(state_r) == ASR_SLEEP && state_r == ASR_WAKE) |->
        (elapsed == 8'h00) ##1 (elapsed == 8'h00 || !slp_en);
  endproperty
  a_wake_restart: assert property (p_wake_restart)
    else $error("inactivity count not restarted on wake");

  property p_restart_clears;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ASR_WAKE && restart_hit) |=> (elapsed == 8'h00);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("detection event did not restart timer");

  property p_sleep_rate;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ASR_SLEEP) |-> (osr_r == asr_sleep_odr(sleep_rate));
  endproperty
  a_sleep_rate: assert property (p_sleep_rate)
    else $error("sleep state not at sleep rate");

  property p_wake_rate;
    @(posedge sys_clk) disable iff (rst)
      (state_r != ASR_SLEEP) |-> (output_sample_rate == wake_rate);
  endproperty
  a_wake_rate: assert property (p_wake_rate)
    else $error("wake rate not applied");

  property p_standby_follows;
    @(posedge sys_clk) disable iff (rst)
      !active_bit |=> (state_r == ASR_STANDBY);
  endproperty
  a_standby_follows: assert property (p_standby_follows)
    else $error("standby bit not obeyed");

  property p_fields_locked;
    @(posedge sys_clk) disable iff (rst)
      (active_bit && !swrst) |=> $stable(ctrl1_r[7:1]);
  endproperty
  a_fields_locked: assert property (p_fields_locked)
    else $error("control one field changed while active");

  property p_new_data_inert;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ASR_SLEEP && new_data_event && func_ev == 4'h0 &&
       slp_en && active_bit && !swrst) |=> (state_r == ASR_SLEEP);
  endproperty
  a_new_data_inert: assert property (p_new_data_inert)
    else $error("new data changed power state");

  property p_cov_to_sleep;
    @(posedge sys_clk) disable iff (rst) to_sleep;
  endproperty
  c_cov_to_sleep: cover property (p_cov_to_sleep);

  property p_cov_to_wake;
    @(posedge sys_clk) disable iff (rst) to_wake && wake_hit;
  endproperty
  c_cov_to_wake: cover property (p_cov_to_wake);

  property p_cov_swrst;
    @(posedge sys_clk) disable iff (rst) swrst && state_r != ASR_STANDBY;
  endproperty
  c_cov_swrst: cover property (p_cov_swrst);

endmodule
